// ==== include/exec_map.svh ====
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
// Register offsets (byte addresses on APB).
`define OFF_CMD 12'h000
`define OFF_ACC 12'h004
`define OFF_PTR0 12'h008
`define OFF_PTR1 12'h00C
`define OFF_PC 12'h010
`define OFF_STATUS 12'h014
`define OFF_CONTROL 12'h018
`define OFF_TIMER_CFG 12'h01C
`define OFF_PWR_CTRL 12'h020
`define OFF_STACK_TOP 12'h024
`define OFF_MEM_ADDR 12'h028
`define OFF_MEM_DATA 12'h02C
// Command word fields.
`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_ARG_LSB 8
`define CMD_ARG_MSB 23
`define CMD_SEL_BIT 24
`define CMD_MODE_LSB 25
`define CMD_MODE_MSB 26
`define CMD_REL_BIT 27
// Field positions.
`define IRQ_EN_BIT 7
`define SOFT_RST_BIT 3
`define BUSY_BIT 0
// Reset values.
`define ACC_RST 8'h00
`define PTR_RST 16'h0000
`define PC_RST 15'h0000
`define TIMER_CFG_RST 8'hFF
`define PWR_CTRL_RST 8'h08
`define STATUS_RST 8'h00
`define CTRL_RST 8'h00
// Timing counts (instruction cycles) and file memory depth.
`define RET_CYCLES 2'h2
`define FILE_DEPTH 128
`endif

// ==== include/exec_pkg.sv ====
package exec_pkg;
  typedef enum logic [3:0] {
    OP_NO_OPERATION = 4'h0,
    OP_DIRECT_STORE = 4'h1,
    OP_INDIRECT_STORE = 4'h2,
    OP_LOAD_TIMER_CFG = 4'h3,
    OP_SOFT_RESET = 4'h4,
    OP_RETURN_SUB = 4'h5,
    OP_RETURN_IRQ = 4'h6
  } opcode_type;
  typedef enum logic [1:0] {
    MODE_PRE_INC = 2'b00,
    MODE_PRE_DEC = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } pointer_mode_code_type;
endpackage

// ==== logic/exec_core.sv ====
`timescale 1ns/1ns
`include "exec_map.svh"
module exec_core
  import exec_pkg::*;
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state seen by the rest of the device.
  output logic [7:0] timer_cfg,
  output logic global_irq_enable,
  output logic soft_reset_pulse,
  output logic busy
);
  logic [7:0] acc_r;
  logic [15:0] ptr_r [0:1];
  logic [14:0] pc_r;
  logic [7:0] status_r;
  logic [7:0] ctrl_r;
  logic [7:0] timer_cfg_r;
  logic [7:0] pwr_ctrl_r;
  logic [14:0] stack_top_r;
  logic [6:0] mem_addr_r;
  logic [31:0] prdata_r;
  logic soft_rst_r;
  logic [1:0] ret_cnt_r;
  logic [31:0] cmd_r;
  logic issue;
  logic bus_wr;
  logic bus_rd;
  logic [3:0] op;
  logic sel;
  logic [15:0] eff_addr;
  logic [15:0] ptr_nxt;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_rdata;
  logic core_rstn;
  logic hit;

  // Decoding that both bus paths share.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `OFF_MEM_DATA) && (a[1:0] == 2'b00);
  endfunction

  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && penable && !pwrite;
  assign hit = mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign issue = bus_wr && (paddr == `OFF_CMD) && (ret_cnt_r == 2'd0);
  assign op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
  assign sel = pwdata[`CMD_SEL_BIT];
  assign busy = (ret_cnt_r != 2'd0);
  assign timer_cfg = timer_cfg_r;
  assign global_irq_enable = ctrl_r[`IRQ_EN_BIT];
  assign soft_reset_pulse = soft_rst_r;
  // Soft reset acts like the reset pin on core state, one cycle later.
  assign core_rstn = presetn && !soft_rst_r;

  // Pointer arithmetic for the indirect store.
  pointer_unit pointer_unit_i (
    .ptr(ptr_r[sel]),
    .pointer_mode_code(pwdata[`CMD_MODE_MSB:`CMD_MODE_LSB]),
    .rel_form(pwdata[`CMD_REL_BIT]),
    .offset(pwdata[`CMD_ARG_LSB+5:`CMD_ARG_LSB]),
    .eff_addr(eff_addr),
    .ptr_nxt(ptr_nxt)
  );

  // Memory write comes from direct or indirect store.
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = 7'h00;
    if (issue) begin
      if (opcode_type'(op) == OP_DIRECT_STORE) begin
        mem_we = 1'b1;
        mem_waddr = pwdata[`CMD_ARG_LSB+6:`CMD_ARG_LSB];
      end
      if (opcode_type'(op) == OP_INDIRECT_STORE) begin
        mem_we = 1'b1;
        mem_waddr = eff_addr[6:0];
      end
    end
  end

  file_memory file_memory_i (
    .pclk(pclk),
    .presetn(core_rstn),
    .core_we(mem_we),
    .core_addr(mem_waddr),
    .core_wdata(acc_r),
    .rd_addr(mem_addr_r),
    .rd_data(mem_rdata)
  );

  // Last command word, for software inspection.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      cmd_r <= 32'h0000_0000;
    end else if (issue) begin
      cmd_r <= pwdata;
    end
  end

  // Accumulator and memory address are loaded by software.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      acc_r <= `ACC_RST;
      mem_addr_r <= 7'h00;
    end else if (bus_wr) begin
      if (paddr == `OFF_ACC) begin
        acc_r <= pwdata[7:0];
      end
      if (paddr == `OFF_MEM_ADDR) begin
        mem_addr_r <= pwdata[6:0];
      end
    end
  end

  // Pointers: software load or update by the indirect store.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      ptr_r[0] <= `PTR_RST;
      ptr_r[1] <= `PTR_RST;
    end else if (issue && opcode_type'(op) == OP_INDIRECT_STORE) begin
      ptr_r[sel] <= ptr_nxt;
    end else if (bus_wr && paddr == `OFF_PTR0) begin
      ptr_r[0] <= pwdata[15:0];
    end else if (bus_wr && paddr == `OFF_PTR1) begin
      ptr_r[1] <= pwdata[15:0];
    end
  end

  // Status flags belong to other instructions; none here touch them.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      status_r <= `STATUS_RST;
    end else if (bus_wr && paddr == `OFF_STATUS) begin
      status_r <= pwdata[7:0];
    end
  end

  // Timer configuration register.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      timer_cfg_r <= `TIMER_CFG_RST;
    end else if (issue && opcode_type'(op) == OP_LOAD_TIMER_CFG) begin
      timer_cfg_r <= acc_r;
    end
  end

  // Soft reset request, one cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= issue && (opcode_type'(op) == OP_SOFT_RESET);
    end
  end

  // Power control survives soft reset so the cause stays visible.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctrl_r <= `PWR_CTRL_RST;
    end else if (issue && opcode_type'(op) == OP_SOFT_RESET) begin
      pwr_ctrl_r[`SOFT_RST_BIT] <= 1'b0;
    end else if (bus_wr && paddr == `OFF_PWR_CTRL) begin
      pwr_ctrl_r <= pwdata[7:0];
    end
  end

  // Return sequencer: one busy cycle after the issue cycle, commands refused meanwhile.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      ret_cnt_r <= 2'd0;
    end else if (issue && (opcode_type'(op) == OP_RETURN_SUB || opcode_type'(op) == OP_RETURN_IRQ)) begin
      ret_cnt_r <= `RET_CYCLES - 2'd1;
    end else if (ret_cnt_r != 2'd0) begin
      ret_cnt_r <= ret_cnt_r - 2'd1;
    end
  end

  // Program counter and stack top.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      pc_r <= `PC_RST;
      stack_top_r <= `PC_RST;
    end else if (issue) begin
      if (opcode_type'(op) == OP_RETURN_SUB || opcode_type'(op) == OP_RETURN_IRQ) begin
        pc_r <= stack_top_r;
        stack_top_r <= `PC_RST;
      end else begin
        pc_r <= pc_r + 15'h0001;
      end
    end else if (bus_wr && paddr == `OFF_STACK_TOP) begin
      stack_top_r <= pwdata[14:0];
    end else if (bus_wr && paddr == `OFF_PC) begin
      pc_r <= pwdata[14:0];
    end
  end

  // Interrupt control register.
  always_ff @(posedge pclk or negedge core_rstn) begin
    if (!core_rstn) begin
      ctrl_r <= `CTRL_RST;
    end else if (issue && opcode_type'(op) == OP_RETURN_IRQ) begin
      ctrl_r[`IRQ_EN_BIT] <= 1'b1;
    end else if (bus_wr && paddr == `OFF_CONTROL) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Read data is registered in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFF_CMD: prdata_r <= cmd_r;
        `OFF_ACC: prdata_r <= {24'h00_0000, acc_r};
        `OFF_PTR0: prdata_r <= {16'h0000, ptr_r[0]};
        `OFF_PTR1: prdata_r <= {16'h0000, ptr_r[1]};
        `OFF_PC: prdata_r <= {17'h0_0000, pc_r};
        `OFF_STATUS: prdata_r <= {23'h00_0000, status_r, busy};
        `OFF_CONTROL: prdata_r <= {24'h00_0000, ctrl_r};
        `OFF_TIMER_CFG: prdata_r <= {24'h00_0000, timer_cfg_r};
        `OFF_PWR_CTRL: prdata_r <= {24'h00_0000, pwr_ctrl_r};
        `OFF_STACK_TOP: prdata_r <= {17'h0_0000, stack_top_r};
        `OFF_MEM_ADDR: prdata_r <= {25'h000_0000, mem_addr_r};
        `OFF_MEM_DATA: prdata_r <= {24'h00_0000, mem_rdata};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = bus_rd ? prdata_r : 32'h0000_0000;

  // Checks. Pointer checks compare against the raw pointer registers, so a fault in the
  // arithmetic unit shows up instead of being copied into the expected value.
  direct_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_DIRECT_STORE |-> mem_we && mem_waddr == pwdata[14:8])
    else $error("direct store not written");
  indirect_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26]
    |-> mem_we && mem_waddr == ptr_r[sel][6:0])
    else $error("indirect address wrong");

  // Effective address of the pre-modes and of the relative form.
  pre_inc_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b00
    |-> mem_we && mem_waddr == ptr_r[sel][6:0] + 7'h01)
    else $error("pre increment address wrong");
  pre_dec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b01
    |-> mem_we && mem_waddr == ptr_r[sel][6:0] - 7'h01)
    else $error("pre decrement address wrong");
  rel_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && pwdata[27]
    |-> mem_we && mem_waddr == ptr_r[sel][6:0] + {pwdata[13], pwdata[13:8]})
    else $error("relative address wrong");

  // Pointer value after the store, one case per mode.
  pre_inc_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b00
    |=> ptr_r[$past(sel)] == $past(ptr_r[sel]) + 16'h0001)
    else $error("pre increment wrong");
  pre_dec_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b01
    |=> ptr_r[$past(sel)] == $past(ptr_r[sel]) - 16'h0001)
    else $error("pre decrement wrong");
  post_inc_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b10
    |=> ptr_r[$past(sel)] == $past(ptr_r[sel]) + 16'h0001)
    else $error("post increment wrong");
  post_dec_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[26:25] == 2'b11
    |=> ptr_r[$past(sel)] == $past(ptr_r[sel]) - 16'h0001)
    else $error("post decrement wrong");
  rel_keep_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && pwdata[27]
    |=> ptr_r[$past(sel)] == $past(ptr_r[sel]))
    else $error("relative form moved pointer");
  ptr_wrap_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[25] == 1'b0
    && ptr_r[sel] == 16'hFFFF |=> ptr_r[$past(sel)] == 16'h0000)
    else $error("pointer did not wrap");
  dec_wrap_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_INDIRECT_STORE && !pwdata[27] && pwdata[25] == 1'b1
    && ptr_r[sel] == 16'h0000 |=> ptr_r[$past(sel)] == 16'hFFFF)
    else $error("pointer did not wrap down");

  // Flags, timer configuration and soft reset.
  flags_keep_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue |=> $stable(status_r))
    else $error("status changed by instruction");
  timer_load_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_LOAD_TIMER_CFG |=> timer_cfg_r == $past(acc_r))
    else $error("timer config not loaded");
  soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    issue && opcode_type'(op) == OP_SOFT_RESET |=> soft_rst_r && !pwr_ctrl_r[3]
    ##1 acc_r == 8'h00 && timer_cfg_r == 8'hFF)
    else $error("soft reset incomplete");

  // Returns and the no-operation.
  irq_return_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_RETURN_IRQ |=> ctrl_r[7] && pc_r == $past(stack_top_r))
    else $error("irq return wrong");
  irq_two_cycle_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_RETURN_IRQ |=> busy ##1 !busy)
    else $error("irq return not two cycles");
  sub_return_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_RETURN_SUB |=> busy ##1 !busy)
    else $error("return not two cycles");
  stack_pop_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_RETURN_SUB |=> pc_r == $past(stack_top_r) && stack_top_r == 15'h0000)
    else $error("stack not popped");
  nop_pc_a: assert property (@(posedge pclk) disable iff (!core_rstn)
    issue && opcode_type'(op) == OP_NO_OPERATION |=> pc_r == $past(pc_r) + 15'h0001 && $stable(acc_r))
    else $error("no operation changed state");
endmodule

// ==== logic/file_memory.sv ====
`timescale 1ns/1ns
`include "exec_map.svh"
module file_memory (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Core write port.
  input wire logic core_we,
  input wire logic [6:0] core_addr,
  input wire logic [7:0] core_wdata,
  // Software read port.
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_r [0:`FILE_DEPTH-1];
  // Storage cells, cleared by reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `FILE_DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (core_we) begin
      mem_r[core_addr] <= core_wdata;
    end
  end
  // Read is combinational, the bus latches it.
  assign rd_data = mem_r[rd_addr];
endmodule

// ==== logic/pointer_unit.sv ====
`timescale 1ns/1ns
`include "exec_map.svh"
module pointer_unit
  import exec_pkg::*;
(
  // Pointer and command operands.
  input wire logic [15:0] ptr,
  input wire logic [1:0] pointer_mode_code,
  input wire logic rel_form,
  input wire logic [5:0] offset,
  // Results.
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_nxt
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] rel;
  // Arithmetic wraps modulo the full 16-bit range.
  assign inc = ptr + 16'h0001;
  assign dec = ptr - 16'h0001;
  assign rel = ptr + {{10{offset[5]}}, offset};
  // Select address and updated pointer for the mode in force.
  always_comb begin
    eff_addr = ptr;
    ptr_nxt = ptr;
    if (rel_form) begin
      eff_addr = rel;
    end else begin
      unique case (pointer_mode_code_type'(pointer_mode_code))
        MODE_PRE_INC: begin
          eff_addr = inc;
          ptr_nxt = inc;
        end
        MODE_PRE_DEC: begin
          eff_addr = dec;
          ptr_nxt = dec;
        end
        MODE_POST_INC: begin
          ptr_nxt = inc;
        end
        MODE_POST_DEC: begin
          ptr_nxt = dec;
        end
      endcase
    end
  end
endmodule

// ==== tb/exec_core_tb.sv ====
`timescale 1ns/1ns
`include "exec_map.svh"
module exec_core_tb;
  import exec_pkg::*;
  // Bus, clock and reset signals.
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] timer_cfg;
  logic global_irq_enable;
  logic soft_reset_pulse;
  logic busy;
  // Bench bookkeeping.
  int err_total = 0;
  int checked = 0;
  logic [14:0] exp_pc;
  logic [31:0] rdat;
  logic rerr;
  // Indirect store cases: start pointer, offset, mode, effective address, final pointer.
  logic [15:0] ip_start [6] = '{16'hFFFF, 16'h0000, 16'h0005, 16'h000A, 16'h0040, 16'h0040};
  logic [15:0] ip_off [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020, 16'h001F};
  logic [1:0] ip_mode [6] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00};
  logic [15:0] ip_eff [6] = '{16'h0000, 16'hFFFF, 16'h0005, 16'h000A, 16'h0020, 16'h005F};
  logic [15:0] ip_end [6] = '{16'h0000, 16'hFFFF, 16'h0006, 16'h0009, 16'h0040, 16'h0040};

  exec_core exec_core_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_cfg(timer_cfg),
    .global_irq_enable(global_irq_enable),
    .soft_reset_pulse(soft_reset_pulse),
    .busy(busy)
  );

  // The clock toggles every half period of 5 ns.
  always #5 pclk = ~pclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  // Only the watchdog ends a wait that never gets an answer.
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
    chk({31'h0000_0000, rerr}, 32'h0000_0000);
  endtask

  // Builds a command word from its fields.
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [15:0] arg, input logic sel,
                                      input logic [1:0] mode, input logic rel);
    cmd = {4'h0, rel, mode, sel, arg, 4'h0, op};
  endfunction

  // Reads a data memory cell through the address and data registers.
  task automatic mem_chk(input logic [6:0] a, input logic [7:0] exp);
    wr(`OFF_MEM_ADDR, {25'h000_0000, a});
    rd(`OFF_MEM_DATA, {24'h00_0000, exp});
  endtask

  // Waits out the single busy cycle that follows a return.
  task automatic ret_wait;
    chk({31'h0000_0000, busy}, 32'h0000_0001);
    @(posedge pclk);
    #1;
    chk({31'h0000_0000, busy}, 32'h0000_0000);
  endtask

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  // Main test sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    exp_pc = 15'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    // Reset state.
    chk({24'h00_0000, timer_cfg}, 32'h0000_00FF);
    rd(`OFF_PWR_CTRL, 32'h0000_0008);
    rd(`OFF_ACC, 32'h0000_0000);
    $display("Test reset_values done");

    // Direct store to the top file address.
    wr(`OFF_ACC, 32'h0000_00A5);
    wr(`OFF_CMD, cmd(OP_DIRECT_STORE, 16'h007F, 1'b0, 2'b00, 1'b0));
    exp_pc++;
    rd(`OFF_PC, {17'h0_0000, exp_pc});
    mem_chk(7'h7F, 8'hA5);
    rd(`OFF_STATUS, 32'h0000_0000);
    $display("Test direct_store done");

    // Indirect store in every mode, with wrap and relative offsets.
    for (int i = 0; i < 6; i++) begin
      wr(i[0] ? `OFF_PTR1 : `OFF_PTR0, {16'h0000, ip_start[i]});
      wr(`OFF_ACC, 32'h0000_0010 + 32'(i));
      wr(`OFF_CMD, cmd(OP_INDIRECT_STORE, ip_off[i], i[0], ip_mode[i], i >= 4));
      exp_pc++;
      rd(i[0] ? `OFF_PTR1 : `OFF_PTR0, {16'h0000, ip_end[i]});
      mem_chk(ip_eff[i][6:0], 8'h10 + 8'(i));
      rd(`OFF_STATUS, 32'h0000_0000);
    end
    rd(`OFF_PC, {17'h0_0000, exp_pc});
    $display("Test indirect_store done");

    // Timer configuration load.
    wr(`OFF_ACC, 32'h0000_004F);
    wr(`OFF_CMD, cmd(OP_LOAD_TIMER_CFG, 16'h0000, 1'b0, 2'b00, 1'b0));
    exp_pc++;
    chk({24'h00_0000, timer_cfg}, 32'h0000_004F);
    rd(`OFF_TIMER_CFG, 32'h0000_004F);
    rd(`OFF_STATUS, 32'h0000_0000);
    $display("Test timer_load done");

    // No-operation only advances the program counter.
    wr(`OFF_CMD, cmd(OP_NO_OPERATION, 16'h0000, 1'b0, 2'b00, 1'b0));
    exp_pc++;
    rd(`OFF_PC, {17'h0_0000, exp_pc});
    rd(`OFF_ACC, 32'h0000_004F);
    rd(`OFF_PTR0, 32'h0000_0040);
    rd(`OFF_STATUS, 32'h0000_0000);
    $display("Test no_operation done");

    // Subroutine return.
    wr(`OFF_STACK_TOP, 32'h0000_1234);
    wr(`OFF_CMD, cmd(OP_RETURN_SUB, 16'h0000, 1'b0, 2'b00, 1'b0));
    ret_wait();
    rd(`OFF_PC, 32'h0000_1234);
    chk({31'h0000_0000, global_irq_enable}, 32'h0000_0000);
    rd(`OFF_STATUS, 32'h0000_0000);
    $display("Test return_sub done");

    // Interrupt return.
    wr(`OFF_STACK_TOP, 32'h0000_0555);
    wr(`OFF_CMD, cmd(OP_RETURN_IRQ, 16'h0000, 1'b0, 2'b00, 1'b0));
    ret_wait();
    chk({31'h0000_0000, global_irq_enable}, 32'h0000_0001);
    rd(`OFF_CONTROL, 32'h0000_0080);
    rd(`OFF_PC, 32'h0000_0555);
    rd(`OFF_STATUS, 32'h0000_0000);
    $display("Test return_irq done");

    // Unmapped address answers with an error and zero data.
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    chk({31'h0000_0000, pready}, 32'h0000_0001);
    $display("Test unmapped done");

    // Software reset.
    wr(`OFF_CMD, cmd(OP_SOFT_RESET, 16'h0000, 1'b0, 2'b00, 1'b0));
    chk({31'h0000_0000, soft_reset_pulse}, 32'h0000_0001);
    @(posedge pclk);
    #1;
    chk({31'h0000_0000, soft_reset_pulse}, 32'h0000_0000);
    chk({24'h00_0000, timer_cfg}, 32'h0000_00FF);
    chk({31'h0000_0000, global_irq_enable}, 32'h0000_0000);
    rd(`OFF_ACC, 32'h0000_0000);
    rd(`OFF_PC, 32'h0000_0000);
    rd(`OFF_PTR0, 32'h0000_0000);
    rd(`OFF_PWR_CTRL, 32'h0000_0000);
    $display("Test soft_reset done");
    complete_run();
  end
endmodule
